// file: verilog/hcd_params.svh
// Purpose: Constants of the host command/data port
// Assumes: Host word bits are numbered 0 (LSB) to 15
// Notes:   Offsets are bit positions in the 16-bit host words
`ifndef HCD_PARAMS_SVH
`define HCD_PARAMS_SVH

// ----------------------------------------------------------------
// Output word bits
// ----------------------------------------------------------------
`define HCD_OB_CMD        8
`define HCD_OB_RSVD9      9
`define HCD_OB_IVE        10
`define HCD_OB_MRST       11
`define HCD_OB_TXE        12
`define HCD_OB_ORE        13
`define HCD_OB_RSVD14     14
`define HCD_OB_GIE        15
`define HCD_CTL_RESET     8'h00

// ----------------------------------------------------------------
// Input word bits
// ----------------------------------------------------------------
`define HCD_IB_STATUS     8
`define HCD_IB_VALID      10
`define HCD_IB_RIP        11
`define HCD_IB_FIFO_RDY   12
`define HCD_IB_OUT_RDY    13
`define HCD_IB_IRQ        15

// ----------------------------------------------------------------
// Framing and buffering
// ----------------------------------------------------------------
`define HCD_CMD_PARAMS    3'h4
`define HCD_FIFO_DEPTH    8
`define HCD_FIFO_WIDTH    10

`endif

// file: verilog/hcd_pkg.sv
// Purpose: Types of the host command/data port
// Assumes: Nothing beyond the constants header
// Notes:   States are Gray coded along test, idle, fail
package hcd_pkg;

	// ----------------------------------------------------------------
	// Port state
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		HCD_ST_TEST = 2'b00,
		HCD_ST_IDLE = 2'b01,
		HCD_ST_FAIL = 2'b11
	} hcd_state_t;

	// ----------------------------------------------------------------
	// Kind of byte handed to the on-board side
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		HCD_K_DATA  = 2'b00,
		HCD_K_CMD   = 2'b01,
		HCD_K_PARAM = 2'b10
	} hcd_kind_t;

endpackage

// file: verilog/hcd_port.sv
// Purpose: Host command/data port with its transmit FIFO
// Assumes: Host strobes arrive from logic on the same clock
// Notes:   A host write carries a bit mask, so single-bit and byte writes share one path
`timescale 1ns/100ps
`include "hcd_params.svh"

// ----------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------
module hcd_fifo #(
	parameter int WIDTH = `HCD_FIFO_WIDTH,
	parameter int DEPTH = `HCD_FIFO_DEPTH
) (
	input  wire logic             clock,     // 25 MHz clock
	input  wire logic             rst_n,     // Async reset
	input  wire logic             flush,     // Drop all entries
	input  wire logic             in_valid,  // Write request
	output logic                  in_ready,  // Space available
	input  wire logic [WIDTH-1:0] in_data,   // Write data
	output logic                  out_valid, // Entry available
	input  wire logic             out_ready, // Drain request
	output logic      [WIDTH-1:0] out_data   // Head entry
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW-1:0]    rd_ptr_next;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	always_comb
	begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next  = count_reg;
		if (flush)
		begin
			wr_ptr_next = '0;
			rd_ptr_next = '0;
			count_next  = '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop)
			begin
				count_next = count_reg + 1'b1;
			end
			else if (pop && !push)
			begin
				count_next = count_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	// Storage needs no reset; count guards every read
	always_ff @(posedge clock)
	begin
		if (push && !flush)
		begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_ptr_reg];
endmodule

// ----------------------------------------------------------------
// Host port
// ----------------------------------------------------------------
module hcd_port #(
	parameter int FIFO_DEPTH = `HCD_FIFO_DEPTH
) (
	input  wire logic        clock,          // 25 MHz clock
	input  wire logic        rst_n,          // Async power-up reset
	input  wire logic        host_wr,        // Host write strobe
	input  wire logic [15:0] host_wr_mask,   // Bits touched by the write
	input  wire logic [15:0] host_wr_data,   // Values of touched bits
	output logic      [15:0] host_rd_word,   // Input word seen by the host
	output logic             host_irq,       // Interrupt to the host
	output logic             tx_valid,       // Byte for the on-board side
	input  wire logic        tx_ready,       // On-board side takes it
	output hcd_pkg::hcd_kind_t tx_kind,      // Data, command or parameter
	output logic      [7:0]  tx_byte,        // Byte value
	input  wire logic        rx_valid,       // On-board byte for the host
	output logic             rx_ready,       // Port can take it
	input  wire logic        rx_status,      // Byte is completion status
	input  wire logic [7:0]  rx_byte,        // Byte value
	output logic             test_run,       // Self-test is running
	input  wire logic        test_done,      // Self-test finished
	input  wire logic        test_pass,      // Self-test result
	output logic             test_error      // Self-test failed
);
	import hcd_pkg::*;

	localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;

	hcd_state_t       state_reg;
	hcd_state_t       state_next;
	logic [7:0]       ctl_reg;
	logic [7:0]       ctl_next;
	logic [2:0]       left_reg;
	logic [2:0]       left_next;
	logic [7:0]       in_byte_reg;
	logic [7:0]       in_byte_next;
	logic             in_stat_reg;
	logic             in_stat_next;
	logic             valid_reg;
	logic             valid_next;
	logic             err_reg;
	logic             err_next;
	logic [15:0]      rd_word_next;
	logic             irq_next;
	logic             rx_ready_next;
	logic [15:0]      new_word;
	logic             byte_wr;
	logic             mrst;
	logic             f_in_valid;
	logic             f_in_ready;
	logic [9:0]       f_in_data;
	logic [9:0]       f_out_data;
	logic             out_rdy;
	logic             fifo_rdy;
	logic [OCC_W-1:0] occ_reg;
	logic [OCC_W-1:0] occ_next;

	// ----------------------------------------------------------------
	// Decode of a host write
	// ----------------------------------------------------------------
	// New word value of the bits the host touched; bit 8 comes from this write when
	// present so that a combined write still frames correctly.
	always_comb
	begin
		new_word = ({ctl_reg, 8'h00} & ~host_wr_mask) | (host_wr_data & host_wr_mask);
		mrst     = host_wr && host_wr_mask[`HCD_OB_MRST] && host_wr_data[`HCD_OB_MRST];
		byte_wr  = host_wr && (host_wr_mask[7:0] == 8'hff) && !mrst;
	end

	// ----------------------------------------------------------------
	// Control bits, framing and status
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next   = state_reg;
		ctl_next     = ctl_reg;
		left_next    = left_reg;
		in_byte_next = in_byte_reg;
		in_stat_next = in_stat_reg;
		valid_next   = valid_reg;
		err_next     = err_reg;
		f_in_valid   = 1'b0;
		f_in_data    = {HCD_K_DATA, 8'h00};

		if (mrst)
		begin
			// Same state as power-up: controls cleared, bit 9 forced low
			ctl_next     = `HCD_CTL_RESET;
			state_next   = HCD_ST_TEST;
			left_next    = 3'h0;
			in_byte_next = 8'h00;
			in_stat_next = 1'b0;
			valid_next   = 1'b0;
			err_next     = 1'b0;
		end
		else
		begin
			if (host_wr)
			begin
				ctl_next = new_word[15:8];
				// Any touch of bit 10 is the host's acknowledge
				if (host_wr_mask[`HCD_OB_IVE])
				begin
					valid_next = 1'b0;
				end
			end

			unique case (state_reg)
				HCD_ST_TEST:
				begin
					if (test_done)
					begin
						state_next = test_pass ? HCD_ST_IDLE : HCD_ST_FAIL;
						err_next   = !test_pass;
					end
				end
				HCD_ST_IDLE:
				begin
					// A byte written while the FIFO is full is lost; hosts wait for bit 12
					if (byte_wr && f_in_ready)
					begin
						f_in_valid = 1'b1;
						// Trailing block bytes stay parameters even while bit 8 is still set
						if (left_reg != 3'h0)
						begin
							f_in_data = {HCD_K_PARAM, host_wr_data[7:0]};
							left_next = left_reg - 3'h1;
						end
						else if (new_word[`HCD_OB_CMD])
						begin
							f_in_data = {HCD_K_CMD, host_wr_data[7:0]};
							left_next = `HCD_CMD_PARAMS;
						end
						else
						begin
							f_in_data = {HCD_K_DATA, host_wr_data[7:0]};
						end
					end
					// Set wins: a new byte and an acknowledge in one cycle keep the byte
					if (rx_valid && rx_ready)
					begin
						in_byte_next = rx_byte;
						in_stat_next = rx_status;
						valid_next   = 1'b1;
					end
				end
				HCD_ST_FAIL:
				begin
					// Only a new master reset leaves this state
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg   <= HCD_ST_TEST;
			ctl_reg     <= `HCD_CTL_RESET;
			left_reg    <= 3'h0;
			in_byte_reg <= 8'h00;
			in_stat_reg <= 1'b0;
			valid_reg   <= 1'b0;
			err_reg     <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			ctl_reg     <= ctl_next;
			left_reg    <= left_next;
			in_byte_reg <= in_byte_next;
			in_stat_reg <= in_stat_next;
			valid_reg   <= valid_next;
			err_reg     <= err_next;
		end
	end

	// ----------------------------------------------------------------
	// Transmit FIFO
	// ----------------------------------------------------------------
	hcd_fifo #(
		.WIDTH (`HCD_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.flush     (mrst),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (f_out_data)
	);

	assign tx_kind = hcd_kind_t'(f_out_data[9:8]);
	assign tx_byte = f_out_data[7:0];

	// Shadow of the FIFO fill, so the ready flags can follow the next occupancy
	always_comb
	begin
		occ_next = occ_reg;
		if (mrst)
		begin
			occ_next = '0;
		end
		else if (f_in_valid && !(tx_valid && tx_ready))
		begin
			occ_next = occ_reg + 1'b1;
		end
		else if (!f_in_valid && tx_valid && tx_ready)
		begin
			occ_next = occ_reg - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			occ_reg <= '0;
		end
		else
		begin
			occ_reg <= occ_next;
		end
	end

	// ----------------------------------------------------------------
	// Input word and interrupt
	// ----------------------------------------------------------------
	// Built from next values so the host sees each change on the edge it happens
	always_comb
	begin
		// Next occupancy, so the flag drops on the edge that fills the last slot
		fifo_rdy      = (state_next == HCD_ST_IDLE) && (occ_next != OCC_W'(FIFO_DEPTH)) && !mrst;
		out_rdy       = fifo_rdy;
		rx_ready_next = (state_next == HCD_ST_IDLE) && !valid_next;
		irq_next      = ctl_next[`HCD_OB_GIE - 8]
			&& ((ctl_next[`HCD_OB_IVE - 8] && valid_next)
			|| (ctl_next[`HCD_OB_TXE - 8] && fifo_rdy)
			|| (ctl_next[`HCD_OB_ORE - 8] && out_rdy));
		rd_word_next                     = 16'h0000;
		rd_word_next[7:0]                = in_byte_next;
		rd_word_next[`HCD_IB_STATUS]     = in_stat_next;
		rd_word_next[`HCD_IB_VALID]      = valid_next;
		rd_word_next[`HCD_IB_RIP]        = (state_next != HCD_ST_IDLE);
		rd_word_next[`HCD_IB_FIFO_RDY]   = fifo_rdy;
		rd_word_next[`HCD_IB_OUT_RDY]    = out_rdy;
		rd_word_next[`HCD_IB_IRQ]        = irq_next;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_rd_word <= 16'h0800;
			host_irq     <= 1'b0;
			rx_ready     <= 1'b0;
			test_run     <= 1'b0;
			test_error   <= 1'b0;
		end
		else
		begin
			host_rd_word <= rd_word_next;
			host_irq     <= irq_next;
			rx_ready     <= rx_ready_next;
			test_run     <= (state_next == HCD_ST_TEST);
			test_error   <= err_next;
		end
	end
endmodule

// file: testbench/hcd_port_checker.sv
// Purpose: Port-level assertions for the host command/data port
// Assumes: Sees only the ports of hcd_port
// Notes:   One clock domain, so default clocking and disable are used
`timescale 1ns/100ps

module hcd_port_checker (
	input wire logic              clock,        // Clock
	input wire logic              rst_n,        // Async reset
	input wire logic              host_wr,      // Write strobe
	input wire logic [15:0]       host_wr_mask, // Touched bits
	input wire logic [15:0]       host_wr_data, // Bit values
	input wire logic [15:0]       host_rd_word, // Input word
	input wire logic              host_irq,     // Interrupt
	input wire logic              tx_valid,     // Head valid
	input wire logic              tx_ready,     // Pop
	input wire hcd_pkg::hcd_kind_t tx_kind,     // Head kind
	input wire logic [7:0]        tx_byte,      // Head byte
	input wire logic              rx_valid,     // Byte offered
	input wire logic              rx_ready,     // Byte accepted
	input wire logic              rx_status,    // Status marker
	input wire logic [7:0]        rx_byte,      // Offered byte
	input wire logic              test_run,     // Test running
	input wire logic              test_done,    // Test finished
	input wire logic              test_pass,    // Test result
	input wire logic              test_error    // Test failed
);
	import hcd_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	logic mrst;
	logic ack;
	assign mrst = host_wr && host_wr_mask[11] && host_wr_data[11];
	assign ack  = host_wr && host_wr_mask[10];

	logic       cmd_reg;
	logic       cmd_now;
	logic [2:0] left_reg;
	assign cmd_now = host_wr_mask[8] ? host_wr_data[8] : cmd_reg;

	// Mirrors block framing from the ports; a command byte is only expected outside a block
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_reg  <= 1'b0;
			left_reg <= 3'h0;
		end
		else if (mrst)
		begin
			cmd_reg  <= 1'b0;
			left_reg <= 3'h0;
		end
		else if (host_wr)
		begin
			cmd_reg <= cmd_now;
			if (host_wr_mask[7:0] == 8'hff && host_rd_word[12])
			begin
				left_reg <= (left_reg != 3'h0) ? left_reg - 3'h1 : (cmd_now ? 3'h4 : 3'h0);
			end
		end
	end

	property p_rip;
		mrst |=> host_rd_word[11] && test_run;
	endproperty
	a_rip: assert property (p_rip) else $error("reset flag not raised");
	property p_mrst;
		mrst |=> host_rd_word[15:10] == 6'h02 && !tx_valid && !host_irq;
	endproperty
	a_mrst: assert property (p_mrst) else $error("master reset state wrong");
	property p_ack;
		ack && host_rd_word[10] && !mrst |=> !host_rd_word[10] && rx_ready;
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledge ignored");
	property p_hold;
		host_rd_word[10] && !ack && !mrst |=> host_rd_word[10] && !rx_ready
			&& $stable(host_rd_word[8:0]);
	endproperty
	a_hold: assert property (p_hold) else $error("input byte not held");
	property p_take;
		rx_valid && rx_ready && !host_wr |=> host_rd_word[10]
			&& host_rd_word[8:0] == $past({rx_status, rx_byte});
	endproperty
	a_take: assert property (p_take) else $error("input byte wrong");
	property p_pass;
		test_run && test_done && test_pass && !host_wr |=> !test_run
			&& host_rd_word[13:11] == 3'h6;
	endproperty
	a_pass: assert property (p_pass) else $error("test pass not reported");
	property p_fail;
		test_run && test_done && !test_pass && !host_wr |=> test_error && host_rd_word[11];
	endproperty
	a_fail: assert property (p_fail) else $error("test fail not reported");
	property p_irq;
		host_irq |-> host_rd_word[15] && (host_rd_word[13:12] != 2'h0 || host_rd_word[10]);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without cause");
	property p_cmd;
		host_wr && host_wr_mask[8:0] == 9'h1ff && host_wr_data[8] && !mrst
			&& host_rd_word[13] && !tx_valid && left_reg == 3'h0 |=> tx_valid
			&& tx_kind == HCD_K_CMD
			&& tx_byte == $past(host_wr_data[7:0]);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command byte not queued");
endmodule

bind hcd_port hcd_port_checker chk (.clock(clock), .rst_n(rst_n), .host_wr(host_wr),
	.host_wr_mask(host_wr_mask), .host_wr_data(host_wr_data), .host_rd_word(host_rd_word),
	.host_irq(host_irq), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_kind(tx_kind),
	.tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_status(rx_status),
	.rx_byte(rx_byte), .test_run(test_run), .test_done(test_done), .test_pass(test_pass),
	.test_error(test_error));

// file: testbench/hcd_host_model.sv
// Purpose: Host side of the bit-addressed port
// Assumes: Host logic runs on the port clock
// Notes:   Released lines show inverted values so stale data never looks valid
`timescale 1ns/100ps

module hcd_host_model (
	input  wire logic        clock,        // Port clock
	output logic             host_wr,      // Write strobe
	output logic      [15:0] host_wr_mask, // Touched bits
	output logic      [15:0] host_wr_data  // Bit values
);
	initial
	begin
		host_wr      = 1'b0;
		host_wr_mask = 16'h0000;
		host_wr_data = 16'h0000;
	end

	// One write per call; the strobe is low for a cycle between writes
	task automatic wr(input logic [15:0] m, input logic [15:0] d);
		@(posedge clock);
		host_wr      <= 1'b1;
		host_wr_mask <= m;
		host_wr_data <= d;
		@(posedge clock);
		host_wr      <= 1'b0;
		host_wr_mask <= ~m;
		host_wr_data <= ~d;
	endtask
endmodule

// file: testbench/hcd_port_tb.sv
// Purpose: Self-checking bench for the host command/data port
// Assumes: Host writes come from hcd_host_model
// Notes:   Bench drives the on-board side; FIFO depth stays at 8
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end

module hcd_port_tb;
	import hcd_pkg::*;
	logic             clock, rst_n, host_wr, host_irq, tx_valid, tx_ready;
	logic             rx_valid, rx_ready, rx_status, test_run, test_done, test_pass, test_error;
	logic      [15:0] host_wr_mask, host_wr_data, host_rd_word;
	logic      [7:0]  tx_byte, rx_byte;
	hcd_kind_t        tx_kind;
	int               err_count, cmp_count;

	hcd_host_model host (.clock(clock), .host_wr(host_wr), .host_wr_mask(host_wr_mask),
		.host_wr_data(host_wr_data));
	hcd_port #(.FIFO_DEPTH(8)) uut (.clock(clock), .rst_n(rst_n), .host_wr(host_wr),
		.host_wr_mask(host_wr_mask), .host_wr_data(host_wr_data), .host_rd_word(host_rd_word),
		.host_irq(host_irq), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_kind(tx_kind),
		.tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_status(rx_status),
		.rx_byte(rx_byte), .test_run(test_run), .test_done(test_done), .test_pass(test_pass),
		.test_error(test_error));

	task automatic close_out();
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Self-test finishes well inside the host's time limit
	task automatic do_test(input logic p);
		@(posedge clock);
		test_done <= 1'b1;
		test_pass <= p;
		@(posedge clock);
		test_done <= 1'b0;
		test_pass <= ~p;
		#1;
	endtask

	task automatic pop(input hcd_kind_t k, input logic [7:0] b);
		`CHK("tx_valid", 1'b1, tx_valid)
		`CHK("tx_kind", k, tx_kind)
		`CHK("tx_byte", b, tx_byte)
		@(posedge clock);
		tx_ready <= 1'b1;
		@(posedge clock);
		tx_ready <= 1'b0;
		#1;
	endtask

	task automatic t_boot();
		`CHK("boot word", 16'h0800, host_rd_word)
		`CHK("boot run", 1'b1, test_run)
		do_test(1'b1);
		`CHK("ready word", 16'h3000, host_rd_word)
	endtask

	task automatic t_block();
		host.wr(16'h01ff, 16'h01a0);
		for (int i = 0; i < 4; i++)
			host.wr(16'h01ff, {7'h00, i[0], 8'h10 + 8'(i)});
		for (int i = 0; i < 3; i++)
			host.wr(16'h01ff, {8'h00, 8'h55 + 8'(i)});
		#1;
		`CHK("full ready", 2'h0, host_rd_word[13:12])
		host.wr(16'h01ff, 16'h00ee);
		host.wr(16'h2000, 16'h2000);
		host.wr(16'h8000, 16'h8000);
		#1;
		`CHK("irq full", 1'b0, host_irq)
		pop(HCD_K_CMD, 8'ha0);
		for (int i = 0; i < 4; i++)
			pop(HCD_K_PARAM, 8'h10 + 8'(i));
		for (int i = 0; i < 3; i++)
			pop(HCD_K_DATA, 8'h55 + 8'(i));
		`CHK("drained", 1'b0, tx_valid)
		`CHK("irq ready", 1'b1, host_irq)
		host.wr(16'h8000, 16'h0000);
		host.wr(16'h2000, 16'h0000);
		host.wr(16'h1000, 16'h1000);
		#1;
		`CHK("irq no gie", 1'b0, host_irq)
		host.wr(16'h8000, 16'h8000);
		#1;
		`CHK("irq space", 1'b1, host_irq)
		host.wr(16'h1000, 16'h0000);
	endtask

	task automatic t_rx();
		host.wr(16'h0400, 16'h0400);
		@(posedge clock);
		rx_valid  <= 1'b1;
		rx_status <= 1'b1;
		rx_byte   <= 8'hc3;
		@(posedge clock);
		rx_status <= 1'b0;
		rx_byte   <= 8'h3c;
		#1;
		`CHK("rx status", 11'h5c3, host_rd_word[10:0])
		`CHK("irq valid", 1'b1, host_irq)
		repeat (3) @(posedge clock);
		#1;
		`CHK("rx held", 11'h5c3, host_rd_word[10:0])
		`CHK("rx refused", 1'b0, rx_ready)
		host.wr(16'h0400, 16'h0400);
		#1;
		`CHK("ack clear", 2'h1, {host_rd_word[10], rx_ready})
		@(posedge clock);
		#1;
		`CHK("rx data", 11'h43c, host_rd_word[10:0])
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_byte  <= 8'hc3;
		host.wr(16'h0400, 16'h0000);
		#1;
		`CHK("acked", 2'h0, {host_rd_word[10], host_irq})
	endtask

	task automatic t_mrst();
		host.wr(16'h0200, 16'h0200);
		host.wr(16'h0800, 16'h0800);
		#1;
		`CHK("mrst word", 16'h0800, host_rd_word)
		`CHK("mrst run", 1'b1, test_run)
		do_test(1'b0);
		`CHK("fail err", 2'h3, {test_error, host_rd_word[11]})
		host.wr(16'h01ff, 16'h00aa);
		#1;
		`CHK("fail refuse", 1'b0, tx_valid)
		host.wr(16'h0800, 16'h0800);
		#1;
		`CHK("err cleared", 1'b0, test_error)
		do_test(1'b1);
		`CHK("idle word", 16'h3000, host_rd_word)
		`CHK("idle run", 1'b0, test_run)
	endtask

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	initial
	begin
		repeat (5000) @(posedge clock);
		err_count++;
		$display("MISMATCH timeout exp done got hang");
		close_out();
	end

	initial
	begin
		err_count = 0;
		cmp_count = 0;
		rst_n     = 1'b0;
		tx_ready  = 1'b0;
		rx_valid  = 1'b0;
		rx_status = 1'b0;
		rx_byte   = 8'h00;
		test_done = 1'b0;
		test_pass = 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		t_boot();
		t_block();
		t_rx();
		t_mrst();
		close_out();
	end
endmodule
